// ---- design/pcint_defs.svh ----
`ifndef PCINT_DEFS_SVH
`define PCINT_DEFS_SVH
// ****************************************
// register offsets
// ****************************************
`define PCINT_ADDR_W 12
`define PCINT_PORT_B_CHANGE_FLAGS 12'hE93
`define PCINT_PORT_B_FALLING_ENABLE 12'hE94
`define PCINT_PORT_B_RISING_ENABLE 12'hE95
`define PCINT_PORT_C_CHANGE_FLAGS 12'hE9B
`define PCINT_PORT_C_FALLING_ENABLE 12'hE9C
`define PCINT_PORT_C_RISING_ENABLE 12'hE9D
`define PCINT_PORT_E_CHANGE_FLAGS 12'hEA8
`define PCINT_PORT_E_FALLING_ENABLE 12'hEA9
`define PCINT_PORT_E_RISING_ENABLE 12'hEAA
`define PCINT_PORT_G_CHANGE_FLAGS 12'hEB5
`define PCINT_PORT_G_FALLING_ENABLE 12'hEB6
`define PCINT_PORT_G_RISING_ENABLE 12'hEB7
`define PCINT_IRQ_CTRL 12'hEC0
`define PCINT_IRQ_STATUS 12'hEC1
`define PCINT_IRQ_MASK 12'hEC2
// ****************************************
// fields and reset values
// ****************************************
`define PCINT_G_PIN 5
`define PCINT_G_VALID_MASK 8'h20
`define PCINT_REG_RESET 8'h00
`define PCINT_CTRL_MASTER_EN_BIT 0
`define PCINT_ST_SUMMARY_BIT 0
`define PCINT_ST_WAKE_BIT 1
`endif

// ---- design/pcint_pkg.sv ----
package pcint_pkg;
    typedef logic [7:0] pcint_byte_t;
    typedef enum logic [1:0] {
        PCINT_PORT_B,
        PCINT_PORT_C,
        PCINT_PORT_E,
        PCINT_PORT_G
    } pcint_port_e;
endpackage

// ---- design/pcint_top.sv ----
// Operation
// - every pin of ports b, c and e and only pin 5 of port g detect changes.
// - each pin has a rising detector enabled by its rising bit and a falling one by its falling bit.
// - with both enable bits set a pin responds to edges in either direction.
// - an enabled edge sets the pin's change flag, which holds until software clears it.
// - with the master enable clear, flags still set but no interrupt request is raised.
// - the summary flag is the or of all change flags of all four ports.
// - writing zero to a flag bit clears it and writing one leaves it as it is.
// - an edge seen in the same cycle as a clearing write leaves the flag set.
// - with the master enable set, an enabled edge seen in sleep asks the core to wake.
// - an edge seen in sleep has its flag set before the core runs again.
// - with the master-clear pin or low-voltage programming enabled, port g pin 5 takes no part.
`include "pcint_defs.svh"
module pcint_top (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [`PCINT_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [7:0] second_port_i,
    input wire logic [7:0] third_port_i,
    input wire logic [7:0] fifth_port_i,
    input wire logic port_g_pin5_i,
    input wire logic master_clear_pin_enable_i,
    input wire logic low_voltage_programming_enable_i,
    input wire logic sleep_i,
    output logic change_irq_summary_flag_o,
    output logic change_irq_o,
    output logic wake_request_o,
    output logic irq_o
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [31:0] pin_meta;
    logic [31:0] pin_sync;
    logic [31:0] pin_last;
    wire [31:0] pin_raw = {8'h00, fifth_port_i, third_port_i, second_port_i};
    logic [7:0] g_meta;
    logic g_sync;
    logic g_last;
    logic [1:0] cfg_meta;
    logic [1:0] cfg_sync;

    always_ff @(posedge ref_clk_i) begin
        pin_meta <= pin_raw;
        pin_sync <= pin_meta;
        pin_last <= pin_sync;
        g_meta <= {7'h00, port_g_pin5_i};
        g_sync <= g_meta[0];
        g_last <= g_sync;
        cfg_meta <= {master_clear_pin_enable_i, low_voltage_programming_enable_i};
        cfg_sync <= cfg_meta;
    end

    // ****************************************
    // registers
    // ****************************************
    pcint_pkg::pcint_byte_t flag_b, flag_c, flag_e, flag_g;
    pcint_pkg::pcint_byte_t rise_b, rise_c, rise_e, rise_g;
    pcint_pkg::pcint_byte_t fall_b, fall_c, fall_e, fall_g;
    logic master_en;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    function automatic logic [7:0] edges(input logic [7:0] now, input logic [7:0] last,
                                         input logic [7:0] rise, input logic [7:0] fall);
        edges = (now & ~last & rise) | (~now & last & fall);
    endfunction

    function automatic logic [7:0] next_flag(input logic [7:0] cur, input logic [7:0] ev,
                                             input logic wr, input logic [7:0] wd);
        // written zeros clear, ones keep; a fresh edge always wins
        next_flag = (wr ? (cur & wd) : cur) | ev;
    endfunction

    wire g_off = |cfg_sync;
    wire [7:0] g_pin_now = {2'b00, g_sync, 5'b00000};
    wire [7:0] g_pin_last = {2'b00, g_last, 5'b00000};
    wire [7:0] ev_b = edges(pin_sync[7:0], pin_last[7:0], rise_b, fall_b);
    wire [7:0] ev_c = edges(pin_sync[15:8], pin_last[15:8], rise_c, fall_c);
    wire [7:0] ev_e = edges(pin_sync[23:16], pin_last[23:16], rise_e, fall_e);
    wire [7:0] ev_g = g_off ? 8'h00 : (edges(g_pin_now, g_pin_last, rise_g, fall_g) & `PCINT_G_VALID_MASK);
    wire any_ev = |{ev_b, ev_c, ev_e, ev_g};

    wire wr_fb = wr_i && (addr_i == `PCINT_PORT_B_CHANGE_FLAGS);
    wire wr_fc = wr_i && (addr_i == `PCINT_PORT_C_CHANGE_FLAGS);
    wire wr_fe = wr_i && (addr_i == `PCINT_PORT_E_CHANGE_FLAGS);
    wire wr_fg = wr_i && (addr_i == `PCINT_PORT_G_CHANGE_FLAGS);
    wire wr_nb = wr_i && (addr_i == `PCINT_PORT_B_FALLING_ENABLE);
    wire wr_nc = wr_i && (addr_i == `PCINT_PORT_C_FALLING_ENABLE);
    wire wr_ne = wr_i && (addr_i == `PCINT_PORT_E_FALLING_ENABLE);
    wire wr_ng = wr_i && (addr_i == `PCINT_PORT_G_FALLING_ENABLE);
    wire wr_pb = wr_i && (addr_i == `PCINT_PORT_B_RISING_ENABLE);
    wire wr_pc = wr_i && (addr_i == `PCINT_PORT_C_RISING_ENABLE);
    wire wr_pe = wr_i && (addr_i == `PCINT_PORT_E_RISING_ENABLE);
    wire wr_pg = wr_i && (addr_i == `PCINT_PORT_G_RISING_ENABLE);
    wire wr_ctl = wr_i && (addr_i == `PCINT_IRQ_CTRL);
    wire wr_msk = wr_i && (addr_i == `PCINT_IRQ_MASK);
    wire rd_st = rd_i && (addr_i == `PCINT_IRQ_STATUS);

    wire [7:0] next_flag_b = next_flag(flag_b, ev_b, wr_fb, wdata_i);
    wire [7:0] next_flag_c = next_flag(flag_c, ev_c, wr_fc, wdata_i);
    wire [7:0] next_flag_e = next_flag(flag_e, ev_e, wr_fe, wdata_i);
    wire [7:0] next_flag_g = next_flag(flag_g, ev_g, wr_fg, wdata_i) & `PCINT_G_VALID_MASK;
    wire next_summary = |{next_flag_b, next_flag_c, next_flag_e, next_flag_g};
    // the wake event is taken from the edge itself; the clock keeps running in sleep here
    wire wake_ev = any_ev && sleep_i && master_en;
    wire [1:0] st_ev = {wake_ev, next_summary && master_en};
    wire [1:0] next_irq_status = (rd_st ? 2'b00 : irq_status) | st_ev;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            flag_b <= `PCINT_REG_RESET;
            flag_c <= `PCINT_REG_RESET;
            flag_e <= `PCINT_REG_RESET;
            flag_g <= `PCINT_REG_RESET;
            rise_b <= `PCINT_REG_RESET;
            rise_c <= `PCINT_REG_RESET;
            rise_e <= `PCINT_REG_RESET;
            rise_g <= `PCINT_REG_RESET;
            fall_b <= `PCINT_REG_RESET;
            fall_c <= `PCINT_REG_RESET;
            fall_e <= `PCINT_REG_RESET;
            fall_g <= `PCINT_REG_RESET;
            master_en <= 1'b0;
            irq_mask <= 2'b00;
        end else begin
            flag_b <= next_flag_b;
            flag_c <= next_flag_c;
            flag_e <= next_flag_e;
            flag_g <= next_flag_g;
            if (wr_pb) rise_b <= wdata_i;
            if (wr_pc) rise_c <= wdata_i;
            if (wr_pe) rise_e <= wdata_i;
            if (wr_pg) rise_g <= wdata_i & `PCINT_G_VALID_MASK;
            if (wr_nb) fall_b <= wdata_i;
            if (wr_nc) fall_c <= wdata_i;
            if (wr_ne) fall_e <= wdata_i;
            if (wr_ng) fall_g <= wdata_i & `PCINT_G_VALID_MASK;
            if (wr_ctl) master_en <= wdata_i[`PCINT_CTRL_MASTER_EN_BIT];
            if (wr_msk) irq_mask <= wdata_i[1:0];
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            irq_status <= 2'b00;
            change_irq_summary_flag_o <= 1'b0;
            change_irq_o <= 1'b0;
            wake_request_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            change_irq_summary_flag_o <= next_summary;
            change_irq_o <= next_summary && master_en;
            wake_request_o <= next_summary && master_en && sleep_i;
            irq_o <= |(next_irq_status & irq_mask);
        end
    end

    // ****************************************
    // read path
    // ****************************************
    wire [7:0] rd_mux =
        (addr_i == `PCINT_PORT_B_CHANGE_FLAGS) ? flag_b :
        (addr_i == `PCINT_PORT_C_CHANGE_FLAGS) ? flag_c :
        (addr_i == `PCINT_PORT_E_CHANGE_FLAGS) ? flag_e :
        (addr_i == `PCINT_PORT_G_CHANGE_FLAGS) ? flag_g :
        (addr_i == `PCINT_PORT_B_FALLING_ENABLE) ? fall_b :
        (addr_i == `PCINT_PORT_C_FALLING_ENABLE) ? fall_c :
        (addr_i == `PCINT_PORT_E_FALLING_ENABLE) ? fall_e :
        (addr_i == `PCINT_PORT_G_FALLING_ENABLE) ? fall_g :
        (addr_i == `PCINT_PORT_B_RISING_ENABLE) ? rise_b :
        (addr_i == `PCINT_PORT_C_RISING_ENABLE) ? rise_c :
        (addr_i == `PCINT_PORT_E_RISING_ENABLE) ? rise_e :
        (addr_i == `PCINT_PORT_G_RISING_ENABLE) ? rise_g :
        (addr_i == `PCINT_IRQ_CTRL) ? {7'h00, master_en} :
        (addr_i == `PCINT_IRQ_STATUS) ? {6'h00, irq_status} :
        (addr_i == `PCINT_IRQ_MASK) ? {6'h00, irq_mask} : 8'h00;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule

// ---- tb/pcint_props.sv ----
`include "pcint_defs.svh"
module pcint_props (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [`PCINT_ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] second_port_i,
    input wire logic [7:0] third_port_i,
    input wire logic [7:0] fifth_port_i,
    input wire logic port_g_pin5_i,
    input wire logic sleep_i,
    input wire logic change_irq_summary_flag_o,
    input wire logic change_irq_o,
    input wire logic wake_request_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // pin activity age, so a flag can be tied to a real edge
    // ****************************************
    wire logic [24:0] pins = {second_port_i, third_port_i, fifth_port_i, port_g_pin5_i};
    logic [24:0] pins_q;
    logic [3:0] quiet;
    always_ff @(posedge ref_clk_i) begin
        pins_q <= pins;
        quiet <= (pins_q != pins) ? 4'h0 : ((quiet == 4'hF) ? quiet : quiet + 4'h1);
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    a_reset_clear: assert property ($fell(reset_i) |-> !change_irq_summary_flag_o && !irq_o)
        else $error("flags set right after reset");
    a_flag_cause: assert property ($rose(change_irq_summary_flag_o) |-> quiet < 4'h8)
        else $error("flag set without pin edge");
    a_flag_sticky: assert property ($fell(change_irq_summary_flag_o) |-> $past(wr_i))
        else $error("flag dropped without write");
    a_irq_gated: assert property (change_irq_o |-> change_irq_summary_flag_o || $past(change_irq_summary_flag_o))
        else $error("irq without flag");
    a_wake_sleep: assert property (wake_request_o |-> $past(sleep_i))
        else $error("wake outside sleep");
    a_wake_irq: assert property (wake_request_o |-> change_irq_o)
        else $error("wake without enabled irq");
    a_irq_drop: assert property ($fell(irq_o) |-> $past(rd_i) || $past(wr_i) || $past(rd_i, 2) || $past(wr_i, 2))
        else $error("irq dropped without access");
    a_g_bits: assert property ($past(rd_i) && ($past(addr_i) inside {`PCINT_PORT_G_CHANGE_FLAGS,
        `PCINT_PORT_G_FALLING_ENABLE, `PCINT_PORT_G_RISING_ENABLE}) |-> (rdata_o & ~`PCINT_G_VALID_MASK) == 8'h00)
        else $error("port g unused bit read high");
endmodule

// ---- tb/pcint_pin_model.sv ----
module pcint_pin_model (
    input wire logic ref_clk_i,
    input wire logic [25:0] want_i,
    output logic [7:0] second_port_o,
    output logic [7:0] third_port_o,
    output logic [7:0] fifth_port_o,
    output logic port_g_pin5_o,
    output logic sleep_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins and sleep move only just after an edge, like the core and the board
    always @(posedge ref_clk_i) begin
        {second_port_o, third_port_o, fifth_port_o, port_g_pin5_o, sleep_o} <= want_i;
    end
endmodule

// ---- tb/tb_pin_change_interrupt.sv ----
`include "pcint_defs.svh"
module tb_pin_change_interrupt;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [11:0] addr_i = 12'h000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic mclr_en = 1'b1;
    logic [25:0] want = 26'h003FC00;
    logic [7:0] rdata_o, pb, pc, pe;
    logic pg, slp, summary, cirq, wake, irq;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    pcint_pin_model i_pcint_pin_model (.ref_clk_i(ref_clk_i), .want_i(want), .second_port_o(pb),
        .third_port_o(pc), .fifth_port_o(pe), .port_g_pin5_o(pg), .sleep_o(slp));
    pcint_top i_pcint_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .second_port_i(pb), .third_port_i(pc), .fifth_port_i(pe),
        .port_g_pin5_i(pg), .master_clear_pin_enable_i(mclr_en), .low_voltage_programming_enable_i(1'b0),
        .sleep_i(slp), .change_irq_summary_flag_o(summary), .change_irq_o(cirq), .wake_request_o(wake),
        .irq_o(irq));
    // ****************************************
    // bus and check helpers
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        // one idle edge so a following call never re-raises the strobe in the same step
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        check(rdata_o, exp);
        @(posedge ref_clk_i);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_edges();
        wr(`PCINT_PORT_B_RISING_ENABLE, 8'h01);
        wr(`PCINT_PORT_C_FALLING_ENABLE, 8'h80);
        wr(`PCINT_PORT_E_RISING_ENABLE, 8'h10);
        wr(`PCINT_PORT_E_FALLING_ENABLE, 8'h10);
        wr(`PCINT_PORT_G_RISING_ENABLE, 8'hFF);
        want <= {8'h03, 8'h7E, 8'h10, 1'b1, 1'b0};
        repeat (8) @(posedge ref_clk_i);
        rd(`PCINT_PORT_B_CHANGE_FLAGS, 8'h01);
        rd(`PCINT_PORT_C_CHANGE_FLAGS, 8'h80);
        rd(`PCINT_PORT_G_CHANGE_FLAGS, 8'h00);
        rd(`PCINT_PORT_G_RISING_ENABLE, 8'h20);
        check({7'h00, summary}, 8'h01);
        check({7'h00, cirq}, 8'h00);
        wr(`PCINT_PORT_E_CHANGE_FLAGS, (8'h10 ^ 8'hFF) & 8'h10);
        wr(`PCINT_PORT_B_CHANGE_FLAGS, 8'hFF);
        rd(`PCINT_PORT_E_CHANGE_FLAGS, 8'h00);
        rd(`PCINT_PORT_B_CHANGE_FLAGS, 8'h01);
        want <= {8'h02, 8'h7E, 8'h00, 1'b1, 1'b0};
        repeat (8) @(posedge ref_clk_i);
        rd(`PCINT_PORT_E_CHANGE_FLAGS, 8'h10);
        // release pin g5 from the master-clear function and watch it fall
        wr(`PCINT_PORT_G_FALLING_ENABLE, 8'hFF);
        mclr_en <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        want <= {8'h02, 8'h7E, 8'h00, 1'b0, 1'b0};
        repeat (8) @(posedge ref_clk_i);
        rd(`PCINT_PORT_G_CHANGE_FLAGS, 8'h20);
        wr(`PCINT_PORT_G_CHANGE_FLAGS, 8'h00);
        rd(`PCINT_PORT_G_CHANGE_FLAGS, 8'h00);
    endtask
    task automatic s_race();
        wr(`PCINT_PORT_B_CHANGE_FLAGS, 8'h00);
        wr(`PCINT_PORT_C_CHANGE_FLAGS, 8'h00);
        wr(`PCINT_PORT_E_CHANGE_FLAGS, 8'h00);
        rd(`PCINT_PORT_B_CHANGE_FLAGS, 8'h00);
        check({7'h00, summary}, 8'h00);
        wr(`PCINT_IRQ_CTRL, 8'h01);
        wr(`PCINT_IRQ_MASK, 8'h01);
        want <= {8'h03, 8'h7E, 8'h00, 1'b0, 1'b0};
        // the edge reaches the flag logic in the cycle this write is taken
        repeat (3) @(posedge ref_clk_i);
        wr(`PCINT_PORT_B_CHANGE_FLAGS, 8'h00);
        rd(`PCINT_PORT_B_CHANGE_FLAGS, 8'h01);
        check({7'h00, cirq}, 8'h01);
        check({7'h00, irq}, 8'h01);
        wr(`PCINT_PORT_B_CHANGE_FLAGS, 8'h00);
        rd(`PCINT_IRQ_STATUS, 8'h01);
        repeat (2) @(negedge ref_clk_i);
        check({7'h00, irq}, 8'h00);
    endtask
    task automatic s_sleep();
        wr(`PCINT_PORT_B_FALLING_ENABLE, 8'h01);
        want <= {8'h02, 8'h7E, 8'h00, 1'b0, 1'b1};
        repeat (8) @(negedge ref_clk_i);
        check({7'h00, wake}, 8'h01);
        rd(`PCINT_PORT_B_CHANGE_FLAGS, 8'h01);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        for (int a = 'hE93; a <= 'hEC2; a++) rd(a[11:0], 8'h00);
        s_edges();
        s_race();
        s_sleep();
        tally_and_finish();
    end
endmodule
bind pcint_top pcint_props i_pcint_props (.ref_clk_i, .reset_i, .addr_i, .wr_i, .rd_i, .rdata_o, .second_port_i,
    .third_port_i, .fifth_port_i, .port_g_pin5_i, .sleep_i, .change_irq_summary_flag_o, .change_irq_o,
    .wake_request_o, .irq_o);
